/* File: dv/ivp_core_model.sv */
// ivp_core_model: core and peripheral stand-in, accepts requests and returns from handlers
// assumes the bench raises flags; the handler clears them on acceptance
`timescale 1ns/1ns
`default_nettype none
module ivp_core_model
  import ivp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire ivp_irq_t    irqOut,
  input  wire ivp_periph_t raiseFlags,
  input  wire logic        slow,
  output logic             irqAck,
  output logic             irqReturn,
  output ivp_periph_t      periphFlags
);
  logic [3:0] waitCnt;
  logic [3:0] runCnt;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqAck      <= 1'b0;
      irqReturn   <= 1'b0;
      periphFlags <= '0;
      waitCnt     <= 4'h0;
      runCnt      <= 4'h0;
    end else begin
      irqAck      <= 1'b0;
      irqReturn   <= runCnt == 4'h1;
      periphFlags <= irqAck ? raiseFlags : periphFlags | raiseFlags;
      if (runCnt != 4'h0) begin
        runCnt <= runCnt - 4'h1;
      end
      // slow answer holds acceptance off for three extra cycles
      if (irqOut.irqReq && !irqAck && runCnt == 4'h0) begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt >= (slow ? 4'h3 : 4'h0)) begin
          irqAck  <= 1'b1;
          waitCnt <= 4'h0;
          runCnt  <= 4'h8;
        end
      end
    end
  end
endmodule : ivp_core_model
`default_nettype wire

/* File: dv/ivp_interrupt_vector_and_power_mode_tb_top.sv */
// ivp tb top: register case, then table of mode and wake cases, then nmi, priority and reset cases
// assumes ivp_core_model as the core and ivp_props bound to the design
`timescale 1ns/1ns
`default_nettype none
module ivp_interrupt_vector_and_power_mode_tb_top
  import ivp_pkg::*;
  ;
  typedef struct {
    logic [2:0]  m;
    logic [7:0]  mask;
    logic [7:0]  g;
    ivp_periph_t f;
    logic [3:0]  p;
    logic [15:0] v;
  } ivp_row_t;
  // sub clock is not fixed in the deep modes, so it is masked there
  ivp_row_t rows [6] = '{
    '{MODE_RUN, 8'hFF, 8'hFF, 28'h0000002, 4'h1, 16'hFFE2},
    '{MODE_S0, 8'hFF, 8'h7F, 28'h0040000, 4'h6, 16'hFFEC},
    '{MODE_S1, 8'hFF, 8'h77, 28'h0080000, 4'h5, 16'hFFEA},
    '{MODE_S2, 8'hDF, 8'h13, 28'h0020000, 4'h5, 16'hFFEA},
    '{MODE_S3, 8'hDF, 8'h11, 28'h0100000, 4'h5, 16'hFFEA},
    '{MODE_S4, 8'hDF, 8'h00, 28'h0010000, 4'h4, 16'hFFE8}};
  logic [15:0]     fa [4] = '{16'h0C00, 16'h01FF, 16'h0600, 16'h0BFF};
  logic            core_clk, rst, globalIntEnable, fetchValid, modeWrite, regWr, regRd, slow;
  logic            watchdogExpire, flash_key_violation, osc_fault_flag, flash_access_violation_flag;
  logic            irqAck, irqReturn, sysReset, extResetPin, extNmiPin;
  logic [15:0]     fetchAddr, regWdata, regRdata;
  logic [3:0]      regAddr;
  logic [2:0]      modeSel, powerMode;
  logic [RC_W-1:0] resetCause;
  ivp_irq_t        irqOut;
  ivp_gates_t      gates;
  ivp_periph_t     periphFlags, raiseFlags;
  int              n_fail, num_checks;
  wire logic [2:0] watch = {irqOut.irqReq, irqAck, irqReturn};

  ivp_interrupt_vector_and_power_mode i_ivp_interrupt_vector_and_power_mode (
    .core_clk(core_clk), .rst(rst), .extResetPin(extResetPin), .extNmiPin(extNmiPin),
    .watchdogExpire(watchdogExpire), .flash_key_violation(flash_key_violation),
    .osc_fault_flag(osc_fault_flag), .flash_access_violation_flag(flash_access_violation_flag),
    .periphFlags(periphFlags), .globalIntEnable(globalIntEnable), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr), .irqAck(irqAck), .irqReturn(irqReturn), .modeWrite(modeWrite),
    .modeSel(modeSel), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irqOut(irqOut), .sysReset(sysReset), .gates(gates),
    .powerMode(powerMode), .resetCause(resetCause));
  ivp_core_model i_ivp_core_model (
    .core_clk(core_clk), .rst(rst), .irqOut(irqOut), .raiseFlags(raiseFlags), .slow(slow),
    .irqAck(irqAck), .irqReturn(irqReturn), .periphFlags(periphFlags));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic waitfor(input int k);
    for (int n = 0; n < 40 && watch[k] !== 1'b1; n++) @(negedge core_clk);
    chk("handshake", watch[k], 1'b1);
  endtask : waitfor
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd   <= 1'b0;
    @(negedge core_clk);
    chk("regRdata", regRdata, e);
  endtask : rd
  task automatic setmode(input logic [2:0] m);
    @(posedge core_clk);
    modeSel   <= m;
    modeWrite <= 1'b1;
    @(posedge core_clk);
    modeWrite <= 1'b0;
  endtask : setmode
  task automatic raise(input ivp_periph_t f);
    @(posedge core_clk);
    raiseFlags <= f;
    slow       <= ~slow;
    @(posedge core_clk);
    raiseFlags <= '0;
  endtask : raise
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
  initial begin
    {rst, globalIntEnable, fetchValid, modeWrite, regWr, regRd, slow} = 7'h40;
    {watchdogExpire, flash_key_violation, osc_fault_flag, flash_access_violation_flag} = 4'h0;
    {extResetPin, extNmiPin} = 2'h0;
    {fetchAddr, regWdata, regAddr, modeSel} = '0;
    raiseFlags = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    globalIntEnable <= 1'b1;
    settle(2);
    chk("resetCause", resetCause, 5'h01);
    wr(4'h2, 16'h001F);
    rd(4'h2, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(4'h3, 16'h0005);
    rd(4'h3, 16'h0000);
    wr(4'h4, 16'h0123);
    wr(4'h5, 16'h000A);
    rd(4'h5, 16'hA123);
    rd(4'h4, VEC_TICK);
    $display("register case done");
    foreach (rows[r]) begin
      setmode(rows[r].m);
      settle(2);
      chk("gates", gates & rows[r].mask, rows[r].g);
      chk("powerMode", powerMode, rows[r].m);
      raise(rows[r].f);
      waitfor(2);
      chk("irqPrio", irqOut.irqPrio, rows[r].p);
      chk("irqVector", irqOut.irqVector, rows[r].v);
      waitfor(1);
      settle(2);
      chk("wakeGates", gates, GATES_RUN);
      setmode(MODE_S4);
      waitfor(0);
      settle(3);
      chk("restoredMode", powerMode, rows[r].m);
      chk("restoredGates", gates & rows[r].mask, rows[r].g);
    end
    $display("mode rows done");
    wr(4'h0, 16'h0002);
    globalIntEnable <= 1'b0;
    @(posedge core_clk);
    osc_fault_flag <= 1'b1;
    @(posedge core_clk);
    osc_fault_flag <= 1'b0;
    waitfor(2);
    chk("nmiPrio", irqOut.irqPrio, 4'hE);
    chk("nmiVector", irqOut.irqVector, 16'hFFFC);
    waitfor(0);
    @(posedge core_clk);
    flash_access_violation_flag <= 1'b1;
    @(posedge core_clk);
    flash_access_violation_flag <= 1'b0;
    settle(6);
    chk("nmiMasked", irqOut.irqReq, 1'b0);
    wr(4'h0, 16'h0001);
    @(posedge core_clk);
    extNmiPin <= 1'b1;
    waitfor(2);
    chk("pinNmiPrio", irqOut.irqPrio, PRIO_NMI);
    chk("pinNmiVector", irqOut.irqVector, VEC_NMI);
    @(posedge core_clk);
    extNmiPin <= 1'b0;
    waitfor(0);
    $display("nmi case done");
    raise(28'h0040002);
    settle(4);
    chk("gieMasked", irqOut.irqReq, 1'b0);
    @(posedge core_clk);
    globalIntEnable <= 1'b1;
    waitfor(2);
    chk("topPrio", irqOut.irqPrio, 4'h6);
    waitfor(0);
    $display("priority case done");
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      fetchValid <= i < 4;
      fetchAddr <= fa[i % 4];
      watchdogExpire <= i == 4;
      flash_key_violation <= i == 5;
      @(posedge core_clk);
      {fetchValid, watchdogExpire, flash_key_violation} <= 3'h0;
      @(negedge core_clk);
      chk("sysReset", sysReset, i != 0);
    end
    @(posedge core_clk);
    extResetPin <= 1'b1;
    settle(3);
    chk("pinReset", sysReset, 1'b1);
    chk("resetCause", resetCause[4:1], 4'hF);
    @(posedge core_clk);
    extResetPin <= 1'b0;
    $display("reset cause case done");
    setmode(MODE_S3);
    settle(1);
    chk("sleepBefore", powerMode, MODE_S3);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    settle(1);
    chk("rerunPulse", sysReset, 1'b1);
    chk("rerunCause", resetCause, 5'h01);
    chk("rerunGates", gates, GATES_RUN);
    chk("rerunMode", powerMode, MODE_RUN);
    chk("rerunReq", irqOut.irqReq, 1'b0);
    $display("mid-run reset case done");
    end_sim();
  end
endmodule : ivp_interrupt_vector_and_power_mode_tb_top

bind ivp_interrupt_vector_and_power_mode ivp_props i_ivp_props (
  .core_clk(core_clk), .rst(rst), .watchdogExpire(watchdogExpire), .fetchValid(fetchValid),
  .fetchAddr(fetchAddr), .irqAck(irqAck), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .irqOut(irqOut), .sysReset(sysReset), .gates(gates), .powerMode(powerMode));
`default_nettype wire

/* File: dv/ivp_props.sv */
// ivp_props: port-level assertions for the vector and power mode block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none
module ivp_props
  import ivp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        watchdogExpire,
  input wire logic        fetchValid,
  input wire logic [15:0] fetchAddr,
  input wire logic        irqAck,
  input wire logic [3:0]  regAddr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  input wire ivp_irq_t    irqOut,
  input wire logic        sysReset,
  input wire ivp_gates_t  gates,
  input wire logic [2:0]  powerMode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_bad_fetch;
    fetchValid && (fetchAddr <= MODREG_HI || (fetchAddr >= UNUSED_LO && fetchAddr <= UNUSED_HI));
  endsequence
  // mode held for a cycle, so the registered gates have caught up
  sequence s_held(logic [2:0] m);
    powerMode == m && $stable(powerMode);
  endsequence
  sequence s_wake;
    !irqOut.irqReq ##[0:1] gates == GATES_RUN;
  endsequence

  a_vec_word: assert property (irqOut.irqReq |-> irqOut.irqVector == {11'h7FF, irqOut.irqPrio, 1'b0})
    else $error("vector word does not match priority");
  a_wdt_reset: assert property (watchdogExpire |=> sysReset)
    else $error("watchdog expiry gave no reset");
  a_fetch_reset: assert property (s_bad_fetch |=> sysReset)
    else $error("bad fetch gave no reset");
  a_run_gates: assert property (s_held(MODE_RUN) |-> gates == GATES_RUN)
    else $error("run mode gates not all on");
  a_level_zero: assert property (s_held(MODE_S0) |-> gates == 8'h7F)
    else $error("level zero gates wrong");
  a_level_one: assert property (s_held(MODE_S1) |-> gates == 8'h77)
    else $error("level one gates wrong");
  a_level_two: assert property (s_held(MODE_S2) |-> (gates & 8'hDF) == 8'h13)
    else $error("level two gates wrong");
  a_level_three: assert property (s_held(MODE_S3) |-> (gates & 8'hDF) == 8'h11)
    else $error("level three gates wrong");
  a_level_four: assert property (s_held(MODE_S4) |-> (gates & 8'hDF) == 8'h00)
    else $error("level four gates wrong");
  a_ack_wake: assert property (irqAck |=> s_wake)
    else $error("accepted request did not wake");
  a_unmapped_rd: assert property (regRd && regAddr > 4'h5 |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule : ivp_props
`default_nettype wire

/* File: rtl/ivp_interrupt_vector_and_power_mode.sv */
// ivp_interrupt_vector_and_power_mode: priority vectoring, reset causes, power mode gates
// assumes core and peripherals on core_clk; pins (external reset/nmi) are asynchronous
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module ivp_interrupt_vector_and_power_mode
  import ivp_pkg::*;
#(
  parameter logic [15:0] HANDLER_DEFAULT = 16'hC000
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // asynchronous pins
  input  wire logic        extResetPin,
  input  wire logic        extNmiPin,
  // same-domain events
  input  wire logic        watchdogExpire,
  input  wire logic        flash_key_violation,
  input  wire logic        osc_fault_flag,
  input  wire logic        flash_access_violation_flag,
  input  wire ivp_periph_t periphFlags,
  input  wire logic        globalIntEnable,
  input  wire logic        fetchValid,
  input  wire logic [15:0] fetchAddr,
  // core handshake: ack takes the vector, ret ends the handler
  input  wire logic        irqAck,
  input  wire logic        irqReturn,
  input  wire logic        modeWrite,
  input  wire logic [2:0]  modeSel,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  output ivp_irq_t         irqOut,
  output logic             sysReset,
  output ivp_gates_t       gates,
  output logic [2:0]       powerMode,
  output logic [RC_W-1:0]  resetCause
);

  localparam logic [3:0] REG_NMI_EN   = 4'h0;
  localparam logic [3:0] REG_NMI_FLG  = 4'h1;
  localparam logic [3:0] REG_CAUSE    = 4'h2;
  localparam logic [3:0] REG_MODE     = 4'h3;
  localparam logic [3:0] REG_VEC_LO   = 4'h4;
  localparam logic [3:0] REG_VEC_HI   = 4'h5;

  typedef struct packed {
    logic [1:0]       rstSync;
    logic [1:0]       nmiSync;
    logic             nmiPrev;
    logic [NM_W-1:0]  nmiEn;
    logic [NM_W-1:0]  nmiFlag;
    logic [RC_W-1:0]  cause;
    logic             powerUp;
    ivp_mode_t        mode;
    ivp_mode_t        savedMode;
    logic [2:0]       modeCode;
    logic             inHandler;
    ivp_irq_t         irq;
    logic             sysReset;
    ivp_gates_t       gates;
    logic [15:0]      rdata;
  } ivp_state_t;

  ivp_state_t st_reg;
  ivp_state_t st_next;

  // handler address table, written over the register port
  logic [15:0] handlerTable [NSRC];
  logic [15:0] vecIdx;

  logic [NSRC-1:0] reqVec;
  logic [3:0]      bestPrio;
  logic            anyReq;
  logic            fetchBad;
  logic            nmiEdge;
  logic [RC_W-1:0] newCause;

  function automatic ivp_gates_t mode_gates(input ivp_mode_t m);
    ivp_gates_t g;
    g = GATES_RUN;
    case (m)
      full_run_state: g = GATES_RUN;
      sleep_level_zero: g.cpuRun = 1'b0;
      sleep_level_one: begin
        g.cpuRun    = 1'b0;
        g.loopCtlOn = 1'b0;
      end
      sleep_level_two: begin
        g.cpuRun      = 1'b0;
        g.masterClkOn = 1'b0;
        g.loopCtlOn   = 1'b0;
        g.oscClkOn    = 1'b0;
      end
      sleep_level_three: begin
        g.cpuRun      = 1'b0;
        g.masterClkOn = 1'b0;
        g.loopCtlOn   = 1'b0;
        g.oscClkOn    = 1'b0;
        g.dcGenOn     = 1'b0;
      end
      sleep_level_four: begin
        g.cpuRun      = 1'b0;
        g.masterClkOn = 1'b0;
        g.loopCtlOn   = 1'b0;
        g.oscClkOn    = 1'b0;
        g.dcGenOn     = 1'b0;
        g.auxClkOn    = 1'b0;
        g.crystalOn   = 1'b0;
      end
      default: g = GATES_RUN;
    endcase
    return g;
  endfunction : mode_gates

  function automatic ivp_mode_t decode_mode(input logic [2:0] s);
    case (s)
      MODE_S0: return sleep_level_zero;
      MODE_S1: return sleep_level_one;
      MODE_S2: return sleep_level_two;
      MODE_S3: return sleep_level_three;
      MODE_S4: return sleep_level_four;
      default: return full_run_state;
    endcase
  endfunction : decode_mode

  function automatic logic [2:0] encode_mode(input ivp_mode_t m);
    case (m)
      sleep_level_zero:  return MODE_S0;
      sleep_level_one:   return MODE_S1;
      sleep_level_two:   return MODE_S2;
      sleep_level_three: return MODE_S3;
      sleep_level_four:  return MODE_S4;
      default:           return MODE_RUN;
    endcase
  endfunction : encode_mode

  // one request line per priority level; flags remain in their modules
  always_comb begin
    reqVec = '0;
    reqVec[PRIO_NMI] = |(st_reg.nmiFlag & st_reg.nmiEn);
    reqVec[PRIO_MAILBOX] = globalIntEnable & (periphFlags.mailboxOut | periphFlags.mailboxIn);
    reqVec[PRIO_CONVERTER] = globalIntEnable
                           & (periphFlags.converterOverflow | periphFlags.converterResult);
    reqVec[PRIO_WDT_IVAL] = globalIntEnable & periphFlags.watchdogIval;
    reqVec[PRIO_SER_RX]   = globalIntEnable & periphFlags.serialReceive;
    reqVec[PRIO_SER_TX]   = globalIntEnable & periphFlags.serialTransmit;
    reqVec[PRIO_CC0]      = globalIntEnable & periphFlags.captureCompare[0];
    reqVec[PRIO_TIMER]    = globalIntEnable
                          & (|periphFlags.captureCompare[2:1] | periphFlags.timerOverflow);
    reqVec[PRIO_PORT_ONE] = globalIntEnable & (|periphFlags.portOnePins);
    reqVec[PRIO_PORT_TWO] = globalIntEnable & (|periphFlags.portTwoPins);
    reqVec[PRIO_TICK]     = globalIntEnable & periphFlags.basicTick;
  end

  // highest set level wins
  always_comb begin
    bestPrio = '0;
    anyReq   = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (reqVec[i]) begin
        bestPrio = PRIO_W'(i);
        anyReq   = 1'b1;
      end
    end
  end

  assign fetchBad = fetchValid
                  & ((fetchAddr <= MODREG_HI)
                  | ((fetchAddr >= UNUSED_LO) & (fetchAddr <= UNUSED_HI)));
  assign nmiEdge  = st_reg.nmiSync[1] & ~st_reg.nmiPrev;
  assign newCause = {fetchBad, flash_key_violation, watchdogExpire, st_reg.rstSync[1], st_reg.powerUp};
  assign vecIdx   = VEC_BASE + {11'h000, st_reg.irq.irqPrio, 1'b0};

  // handler table: word i at 0xFFE0 + 2i
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        handlerTable[i] <= HANDLER_DEFAULT;
      end
    end else if (regWr && regAddr == REG_VEC_LO) begin
      handlerTable[regWdata[PRIO_W+11:12]] <= {4'h0, regWdata[11:0]};
    end else if (regWr && regAddr == REG_VEC_HI) begin
      handlerTable[regWdata[PRIO_W+11:12]][15:12] <= regWdata[3:0];
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.rstSync = {st_reg.rstSync[0], extResetPin};
    st_next.nmiSync = {st_reg.nmiSync[0], extNmiPin};
    st_next.nmiPrev = st_reg.nmiSync[1];
    st_next.powerUp = 1'b0;
    // set wins over software clear
    if (regWr && regAddr == REG_NMI_FLG) begin
      st_next.nmiFlag = st_reg.nmiFlag & ~regWdata[NM_W-1:0];
    end
    if (nmiEdge) st_next.nmiFlag[NM_EXT] = 1'b1;
    if (osc_fault_flag) st_next.nmiFlag[NM_OSC] = 1'b1;
    if (flash_access_violation_flag) st_next.nmiFlag[NM_ACC] = 1'b1;
    if (regWr && regAddr == REG_NMI_EN) begin
      st_next.nmiEn = regWdata[NM_W-1:0];
    end
    if (regWr && regAddr == REG_CAUSE) begin
      st_next.cause = st_reg.cause & ~regWdata[RC_W-1:0];
    end
    st_next.cause = st_next.cause | newCause;
    st_next.sysReset = |newCause;
    if (modeWrite && !st_reg.inHandler) begin
      st_next.mode = decode_mode(modeSel);
    end
    // request follows the pending sources and is held low from acknowledge until return
    st_next.irq.irqReq  = anyReq & ~st_reg.inHandler;
    st_next.irq.irqPrio = bestPrio;
    st_next.irq.irqVector = VEC_BASE + {11'h000, bestPrio, 1'b0};
    if (st_reg.irq.irqReq && irqAck) begin
      st_next.savedMode = st_reg.mode;
      st_next.mode      = full_run_state;
      st_next.inHandler = 1'b1;
      st_next.irq.irqReq = 1'b0;
      if (st_reg.irq.irqPrio == PRIO_NMI) begin
        st_next.nmiEn = '0;
      end
    end
    if (irqReturn && st_reg.inHandler) begin
      st_next.mode      = st_reg.savedMode;
      st_next.inHandler = 1'b0;
    end
    st_next.gates = mode_gates(st_next.mode);
    st_next.modeCode = encode_mode(st_next.mode);
    // unassigned bits read zero and keep no storage
    st_next.rdata = '0;
    if (regRd) begin
      case (regAddr)
        REG_NMI_EN:  st_next.rdata = {{(16-NM_W){1'b0}}, st_reg.nmiEn};
        REG_NMI_FLG: st_next.rdata = {{(16-NM_W){1'b0}}, st_reg.nmiFlag};
        REG_CAUSE:   st_next.rdata = {{(16-RC_W){1'b0}}, st_reg.cause};
        REG_MODE:    st_next.rdata = {12'h000, st_reg.inHandler, encode_mode(st_reg.mode)};
        REG_VEC_LO:  st_next.rdata = vecIdx;
        REG_VEC_HI:  st_next.rdata = handlerTable[st_reg.irq.irqPrio];
        default:     st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg           <= '0;
      st_reg.powerUp   <= 1'b1;
      st_reg.mode      <= full_run_state;
      st_reg.savedMode <= full_run_state;
      st_reg.gates     <= GATES_RUN;
      st_reg.modeCode  <= MODE_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdata   = st_reg.rdata;
  assign irqOut     = st_reg.irq;
  assign sysReset   = st_reg.sysReset;
  assign gates      = st_reg.gates;
  assign powerMode  = st_reg.modeCode;
  assign resetCause = st_reg.cause;

endmodule : ivp_interrupt_vector_and_power_mode

`default_nettype wire

/* File: rtl/ivp_pkg.sv */
// ivp_pkg: constants and carriers for the interrupt vector and power mode block
// assumes a single 20 MHz core clock and a 16-bit word address space
package ivp_pkg;

  localparam int ADDR_W = 16;
  localparam int PRIO_W = 4;
  localparam int NSRC   = 16;

  // vector words, one per priority level (priority n at 0xFFE0 + 2n)
  localparam logic [15:0] VEC_BASE      = 16'hFFE0;
  localparam logic [15:0] VEC_TOP       = 16'hFFFF;
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_NMI       = 16'hFFFC;
  localparam logic [15:0] VEC_MAILBOX   = 16'hFFFA;
  localparam logic [15:0] VEC_CONVERTER = 16'hFFF8;
  localparam logic [15:0] VEC_WDT_IVAL  = 16'hFFF4;
  localparam logic [15:0] VEC_SER_RX    = 16'hFFF2;
  localparam logic [15:0] VEC_SER_TX    = 16'hFFF0;
  localparam logic [15:0] VEC_CC0       = 16'hFFEC;
  localparam logic [15:0] VEC_TIMER     = 16'hFFEA;
  localparam logic [15:0] VEC_PORT_ONE  = 16'hFFE8;
  localparam logic [15:0] VEC_PORT_TWO  = 16'hFFE2;
  localparam logic [15:0] VEC_TICK      = 16'hFFE0;

  localparam logic [3:0] PRIO_RESET     = 4'hF;
  localparam logic [3:0] PRIO_NMI       = 4'hE;
  localparam logic [3:0] PRIO_MAILBOX   = 4'hD;
  localparam logic [3:0] PRIO_CONVERTER = 4'hC;
  localparam logic [3:0] PRIO_WDT_IVAL  = 4'hA;
  localparam logic [3:0] PRIO_SER_RX    = 4'h9;
  localparam logic [3:0] PRIO_SER_TX    = 4'h8;
  localparam logic [3:0] PRIO_CC0       = 4'h6;
  localparam logic [3:0] PRIO_TIMER     = 4'h5;
  localparam logic [3:0] PRIO_PORT_ONE  = 4'h4;
  localparam logic [3:0] PRIO_PORT_TWO  = 4'h1;
  localparam logic [3:0] PRIO_TICK      = 4'h0;

  // fetch ranges that force a reset
  localparam logic [15:0] MODREG_LO = 16'h0000;
  localparam logic [15:0] MODREG_HI = 16'h01FF;
  localparam logic [15:0] UNUSED_LO = 16'h0600;
  localparam logic [15:0] UNUSED_HI = 16'h0BFF;

  // reset cause bits
  localparam int RC_POWER = 0;
  localparam int RC_EXT   = 1;
  localparam int RC_WDT   = 2;
  localparam int RC_KEY   = 3;
  localparam int RC_FETCH = 4;
  localparam int RC_W     = 5;

  // power mode select: bits 2..0, only five low-power codes used
  localparam logic [2:0] MODE_RUN  = 3'h0;
  localparam logic [2:0] MODE_S0   = 3'h1;
  localparam logic [2:0] MODE_S1   = 3'h2;
  localparam logic [2:0] MODE_S2   = 3'h3;
  localparam logic [2:0] MODE_S3   = 3'h4;
  localparam logic [2:0] MODE_S4   = 3'h5;

  typedef enum logic [2:0] {
    full_run_state,
    sleep_level_zero,
    sleep_level_one,
    sleep_level_two,
    sleep_level_three,
    sleep_level_four
  } ivp_mode_t;

  // non-maskable group enables and flags, bit order
  localparam int NM_EXT = 0;
  localparam int NM_OSC = 1;
  localparam int NM_ACC = 2;
  localparam int NM_W   = 3;

  // clock and supply gates driven by the mode
  typedef struct packed {
    logic cpuRun;
    logic masterClkOn;
    logic subClkOn;
    logic auxClkOn;
    logic loopCtlOn;
    logic oscClkOn;
    logic dcGenOn;
    logic crystalOn;
  } ivp_gates_t;

  localparam ivp_gates_t GATES_RUN = 8'hFF;

  // maskable peripheral requests; the pending flags stay in each module
  typedef struct packed {
    logic       mailboxOut;
    logic       mailboxIn;
    logic       converterOverflow;
    logic       converterResult;
    logic       watchdogIval;
    logic       serialReceive;
    logic       serialTransmit;
    logic [2:0] captureCompare;
    logic       timerOverflow;
    logic [7:0] portOnePins;
    logic [7:0] portTwoPins;
    logic       basicTick;
  } ivp_periph_t;

  // vectoring handshake toward the core
  typedef struct packed {
    logic        irqReq;
    logic [3:0]  irqPrio;
    logic [15:0] irqVector;
  } ivp_irq_t;

endpackage : ivp_pkg
